/* File: pkg/sktk_consts.svh */
// Constants of the seconds counter timekeeper: offsets, fields, reset values, timing.
// Assumes it is included by bare name from the design files; the package does not include it.
`ifndef SKTK_CONSTS_SVH
`define SKTK_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define SKTK_CLK_HZ 25000000
`define SKTK_HOLD_MS 250
`define SKTK_OSC_START_MS 1
`define SKTK_DIV_LAST 15'h7fff

// ****************************************
// Register map
// ****************************************
`define SKTK_REG_CNT0 3'h0
`define SKTK_REG_CNT3 3'h3
`define SKTK_REG_CTRL 3'h4
`define SKTK_REG_CHG 3'h5
`define SKTK_REG_LAST 3'h5

// ****************************************
// Fields and reset values
// ****************************************
`define SKTK_HALT_BIT 7
`define SKTK_KEY_HI 7
`define SKTK_KEY_LO 4
`define SKTK_KEY_VAL 4'ha
`define SKTK_DIODE_HI 3
`define SKTK_DIODE_LO 2
`define SKTK_DIODE_NONE 2'h1
`define SKTK_DIODE_ONE 2'h2
`define SKTK_RES_HI 1
`define SKTK_RES_LO 0
`define SKTK_RES_OFF 2'h0
`define SKTK_CHG_RST 8'h00
`define SKTK_HALT_RST 1'h0
`define SKTK_CNT_RST 32'h0000_0000
`define SKTK_BYTE_BITS 4'h8

`endif

/* File: pkg/sktk_pkg.sv */
// Types shared by the timekeeper design files.
// Assumes nothing of the include path; it does not use the constants header.
package sktk_pkg;
    typedef enum logic [3:0] {
        SKTK_IDLE,
        SKTK_ADDR,
        SKTK_ACK_ADDR,
        SKTK_PTR,
        SKTK_ACK_PTR,
        SKTK_WR,
        SKTK_ACK_WR,
        SKTK_RD,
        SKTK_RD_ACK
    } sktk_state_e;
endpackage : sktk_pkg

/* File: hw/sktk_sync.sv */
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module sktk_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [W-1:0] d_i,
    output var logic [W-1:0] q_o
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d_i;
        next_q = meta;
    end

    // Reset values are all ones, the idle bus level, so no false SCL or SDA edge appears after reset.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            meta <= {W{1'b1}};
            q_o <= {W{1'b1}};
        end else begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end
endmodule : sktk_sync
`default_nettype wire

/* File: hw/sktk_top.sv */
// Seconds counter timekeeper: 2-wire slave, six byte registers, power-fail reset.
// Assumes scl, sda, the crystal clock and the supply monitor are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
`include "sktk_consts.svh"
module sktk_top import sktk_pkg::*; #(
    // Bus identity; the value is arbitrary.
    parameter logic [6:0] DEV_ADDR = 7'h2a,
    parameter int unsigned HOLD_CYCLES =
        int'((64'd`SKTK_HOLD_MS * 64'd`SKTK_CLK_HZ) / 64'd1000),
    parameter int unsigned OSC_START_CYCLES =
        int'((64'd`SKTK_OSC_START_MS * 64'd`SKTK_CLK_HZ) / 64'd1000)
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output var logic sda_o,
    output var logic sda_oe_o,
    input wire logic osc_clk_i,
    input wire logic power_fail_i,
    output var logic reset_n_o,
    output var logic reset_n_oe_o,
    output var logic osc_run_o,
    output var logic charge_en_o,
    output var logic diode_on_o,
    output var logic [1:0] res_sel_o
);
    // ****************************************
    // Pin sampling and edges
    // ****************************************
    logic [3:0] sy;
    logic scl_s, sda_s, osc_s, pf;
    logic scl_q, sda_q, osc_q;
    logic scl_rise, scl_fall, start, stop, osc_rise;

    sktk_sync #(.W(4)) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .d_i({scl_i, sda_i, osc_clk_i, power_fail_i}),
        .q_o(sy)
    );

    assign {scl_s, sda_s, osc_s} = sy[3:1];

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            osc_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            osc_q <= osc_s;
        end
    end

    // The monitor line is active high: supply at or below the trip point.
    assign pf = sy[0];
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start = scl_s & scl_q & sda_q & ~sda_s;
    assign stop = scl_s & scl_q & ~sda_q & sda_s;
    assign osc_rise = osc_s & ~osc_q;

    // ****************************************
    // Serial slave and registers
    // ****************************************
    sktk_state_e state, next_state;
    logic [3:0] bitcnt, next_bitcnt;
    logic [7:0] rx, next_rx, tx, next_tx, rdata;
    logic [2:0] ptr, next_ptr;
    logic rw, next_rw, sda_oe, next_sda_oe;
    logic [31:0] shadow, next_shadow, cnt;
    logic dirty, next_dirty, halt, next_halt;
    logic [7:0] chg, next_chg;
    logic load_cnt, ptr_adv;

    always_comb begin
        unique case (ptr)
            `SKTK_REG_CTRL: rdata = {halt, 7'h00};
            `SKTK_REG_CHG: rdata = chg;
            default: rdata = shadow[{ptr[1:0], 3'b000} +: 8];
        endcase
    end

    always_comb begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_rx = rx;
        next_tx = tx;
        next_ptr = ptr;
        next_rw = rw;
        next_sda_oe = sda_oe;
        next_shadow = shadow;
        next_dirty = dirty;
        next_halt = halt;
        next_chg = chg;
        load_cnt = 1'b0;
        ptr_adv = 1'b0;
        if (pf) begin
            // A transfer cut by power fail is dropped, partial writes too.
            next_state = SKTK_IDLE;
            next_sda_oe = 1'b0;
            next_bitcnt = 4'h0;
            next_dirty = 1'b0;
        end else if (start || stop) begin
            // Counter bytes land together so the count never holds a mix.
            load_cnt = dirty;
            next_dirty = 1'b0;
            next_sda_oe = 1'b0;
            next_bitcnt = 4'h0;
            next_state = start ? SKTK_ADDR : SKTK_IDLE;
        end else begin
            unique case (state)
                SKTK_IDLE: begin
                end
                SKTK_ADDR, SKTK_PTR, SKTK_WR: begin
                    if (scl_rise) begin
                        next_rx = {rx[6:0], sda_s};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == `SKTK_BYTE_BITS) begin
                        next_bitcnt = 4'h0;
                        next_sda_oe = 1'b1;
                        if (state == SKTK_ADDR) begin
                            if (rx[7:1] == DEV_ADDR) begin
                                next_state = SKTK_ACK_ADDR;
                                next_rw = rx[0];
                                // Snapshot keeps a multi-byte read coherent.
                                next_shadow = cnt;
                            end else begin
                                next_state = SKTK_IDLE;
                                next_sda_oe = 1'b0;
                            end
                        end else if (state == SKTK_PTR) begin
                            next_state = SKTK_ACK_PTR;
                            next_ptr = (rx[7:3] == 5'h00 && rx[2:0] <= `SKTK_REG_LAST)
                                ? rx[2:0] : `SKTK_REG_CNT0;
                        end else begin
                            next_state = SKTK_ACK_WR;
                            ptr_adv = 1'b1;
                            if (ptr <= `SKTK_REG_CNT3) begin
                                next_shadow[{ptr[1:0], 3'b000} +: 8] = rx;
                                next_dirty = 1'b1;
                            end else if (ptr == `SKTK_REG_CTRL) begin
                                next_halt = rx[`SKTK_HALT_BIT];
                            end else begin
                                next_chg = rx;
                            end
                        end
                    end
                end
                SKTK_ACK_ADDR, SKTK_ACK_PTR, SKTK_ACK_WR: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        if (state == SKTK_ACK_ADDR && rw) begin
                            next_state = SKTK_RD;
                            next_tx = rdata;
                            next_sda_oe = ~rdata[7];
                        end else if (state == SKTK_ACK_ADDR) begin
                            next_state = SKTK_PTR;
                        end else begin
                            next_state = SKTK_WR;
                        end
                    end
                end
                SKTK_RD: begin
                    if (scl_rise) begin
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bitcnt == `SKTK_BYTE_BITS) begin
                            next_state = SKTK_RD_ACK;
                            next_sda_oe = 1'b0;
                            next_bitcnt = 4'h0;
                            ptr_adv = 1'b1;
                        end else begin
                            next_tx = {tx[6:0], 1'b0};
                            next_sda_oe = ~tx[6];
                        end
                    end
                end
                SKTK_RD_ACK: begin
                    if (scl_rise && sda_s) begin
                        next_state = SKTK_IDLE;
                    end else if (scl_fall) begin
                        next_state = SKTK_RD;
                        next_tx = rdata;
                        next_sda_oe = ~rdata[7];
                    end
                end
            endcase
        end
        if (ptr_adv) begin
            if (ptr == `SKTK_REG_LAST) begin
                next_ptr = `SKTK_REG_CNT0;
                if (rw) begin
                    next_shadow = cnt;
                end
            end else begin
                next_ptr = ptr + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state <= SKTK_IDLE;
            bitcnt <= 4'h0;
            rx <= 8'h00;
            tx <= 8'h00;
            ptr <= `SKTK_REG_CNT0;
            rw <= 1'b0;
            sda_oe <= 1'b0;
            shadow <= `SKTK_CNT_RST;
            dirty <= 1'b0;
            halt <= `SKTK_HALT_RST;
            chg <= `SKTK_CHG_RST;
        end else begin
            state <= next_state;
            bitcnt <= next_bitcnt;
            rx <= next_rx;
            tx <= next_tx;
            ptr <= next_ptr;
            rw <= next_rw;
            sda_oe <= next_sda_oe;
            shadow <= next_shadow;
            dirty <= next_dirty;
            halt <= next_halt;
            chg <= next_chg;
        end
    end

    // ****************************************
    // Timekeeping, reset output, charger decode
    // ****************************************
    logic [14:0] div, next_div;
    logic [31:0] next_cnt, hold, next_hold;
    logic rst_act, next_rst_act, osc_on, tick;
    logic next_charge, next_diode;
    logic [1:0] next_res;

    always_comb begin
        // In backup with the bit set the oscillator is stopped.
        osc_on = ~pf | ~halt;
        tick = osc_rise & osc_on & (div == `SKTK_DIV_LAST);
        next_div = div;
        next_cnt = cnt;
        if (load_cnt) begin
            next_div = 15'h0000;
            next_cnt = shadow;
        end else if (osc_rise && osc_on) begin
            next_div = div + 15'h0001;
            if (tick && !halt) begin
                next_cnt = cnt + 32'h0000_0001;
            end
        end
        if (pf) begin
            next_rst_act = 1'b1;
            next_hold = halt ? 32'(HOLD_CYCLES + OSC_START_CYCLES)
                : 32'(HOLD_CYCLES);
        end else if (hold != 32'h0000_0000) begin
            next_rst_act = 1'b1;
            next_hold = hold - 32'h0000_0001;
        end else begin
            next_rst_act = 1'b0;
            next_hold = hold;
        end
        next_diode = next_chg[`SKTK_DIODE_HI:`SKTK_DIODE_LO] == `SKTK_DIODE_ONE;
        next_res = next_chg[`SKTK_RES_HI:`SKTK_RES_LO];
        next_charge = (next_chg[`SKTK_KEY_HI:`SKTK_KEY_LO] == `SKTK_KEY_VAL)
            && (next_diode
                || next_chg[`SKTK_DIODE_HI:`SKTK_DIODE_LO] == `SKTK_DIODE_NONE)
            && (next_res != `SKTK_RES_OFF);
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            div <= 15'h0000;
            cnt <= `SKTK_CNT_RST;
            hold <= 32'(HOLD_CYCLES);
            rst_act <= 1'b1;
            osc_run_o <= 1'b1;
            charge_en_o <= 1'b0;
            diode_on_o <= 1'b0;
            res_sel_o <= `SKTK_RES_OFF;
            sda_oe_o <= 1'b0;
            sda_o <= 1'b0;
            reset_n_o <= 1'b0;
            reset_n_oe_o <= 1'b1;
        end else begin
            div <= next_div;
            cnt <= next_cnt;
            hold <= next_hold;
            rst_act <= next_rst_act;
            osc_run_o <= ~pf | ~next_halt;
            charge_en_o <= next_charge;
            diode_on_o <= next_charge & next_diode;
            res_sel_o <= next_charge ? next_res : `SKTK_RES_OFF;
            // Open drain: only ever pull low, release by dropping the enable.
            sda_oe_o <= next_sda_oe;
            sda_o <= 1'b0;
            reset_n_o <= 1'b0;
            reset_n_oe_o <= next_rst_act;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_held8;
        reset_n_oe_o [*8];
    endsequence

    sequence s_pf_gone;
        $fell(pf) ##0 !halt;
    endsequence

    chk_tick_count: assert property (tick && !halt && !load_cnt
        |=> cnt == $past(cnt) + 32'h0000_0001)
        else $error("counter missed a second");
    chk_halt_freeze: assert property (halt && !load_cnt
        |=> cnt == $past(cnt))
        else $error("counter moved while halted");
    chk_ptr_wrap: assert property (ptr_adv && ptr == `SKTK_REG_LAST
        |=> ptr == `SKTK_REG_CNT0)
        else $error("pointer did not wrap");
    chk_ptr_step: assert property (ptr_adv && ptr < `SKTK_REG_LAST
        |=> ptr == $past(ptr) + 3'h1)
        else $error("pointer did not advance");
    chk_pf_reset: assert property (pf |=> reset_n_oe_o)
        else $error("reset not asserted on power fail");
    chk_pf_block: assert property (pf |=> ##1 state == SKTK_IDLE && !sda_oe_o)
        else $error("bus active during power fail");
    chk_hold_len: assert property (s_pf_gone |-> s_held8)
        else $error("reset released too soon");
    chk_hold_extra: assert property ($fell(pf) && $past(halt)
        |-> hold == 32'(HOLD_CYCLES + OSC_START_CYCLES))
        else $error("start-up time missing from hold");
    chk_charge_key: assert property (chg[7:4] != `SKTK_KEY_VAL ##1
        chg[7:4] != `SKTK_KEY_VAL |-> !charge_en_o)
        else $error("charger on without key");
    chk_res_off: assert property (chg[1:0] == `SKTK_RES_OFF ##1
        chg[1:0] == `SKTK_RES_OFF |-> !charge_en_o)
        else $error("charger on with no resistor");
    chk_ptr_load: assert property (state == SKTK_PTR && scl_fall && !pf
        && !start && !stop && bitcnt == `SKTK_BYTE_BITS && rx <= 8'h05
        |=> ptr == $past(rx[2:0]))
        else $error("pointer byte not loaded");
endmodule : sktk_top
`default_nettype wire

/* File: test/sktk_bus_master.sv */
// Behavioural 2-wire bus master that drives the timekeeper's serial pins.
// Assumes a pull-up resolves SDA outside; SCL stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module sktk_bus_master (
    output var logic scl_o,
    output var logic sda_pull_o,
    input wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    // ****************************************
    // Bit and frame primitives
    // ****************************************
    // Data moves only while SCL is low, so no bit is mistaken for START or STOP.
    task automatic bit_io(input logic b, output logic r);
        #40 sda_pull_o = ~b;
        #40 scl_o = 1'b1;
        #80 r = sda_i;
        #80 scl_o = 1'b0;
        #80;
    endtask : bit_io

    task automatic start_cond();
        sda_pull_o = 1'b0;
        #80 scl_o = 1'b1;
        #160 sda_pull_o = 1'b1;
        #160 scl_o = 1'b0;
        #80;
    endtask : start_cond

    task automatic stop_cond();
        sda_pull_o = 1'b1;
        #80 scl_o = 1'b1;
        #160 sda_pull_o = 1'b0;
        #160;
    endtask : stop_cond

    task automatic byte_out(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : byte_out

    task automatic byte_in(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, v[i]);
        end
        bit_io(last, r);
    endtask : byte_in

    task automatic wr(input logic [6:0] a, input logic [7:0] p, input int n,
            input logic [55:0] d, output logic ok);
        logic k;
        start_cond();
        byte_out({a, 1'b0}, ok);
        byte_out(p, k);
        ok &= k;
        for (int i = 0; i < n; i++) begin
            byte_out(d[8 * i +: 8], k);
            ok &= k;
        end
        stop_cond();
    endtask : wr

    task automatic rd(input logic [6:0] a, input int n, output logic [55:0] d, output logic ok);
        logic [7:0] b;
        start_cond();
        byte_out({a, 1'b1}, ok);
        d = '0;
        for (int i = 0; i < n; i++) begin
            byte_in(i == n - 1, b);
            d[8 * i +: 8] = b;
        end
        stop_cond();
    endtask : rd
endmodule : sktk_bus_master
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the timekeeper: bus access, charger decode, halt, reset hold.
// Assumes the bus master model; SDA has a pull-up, the design carries its own assertions.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [6:0] DEV = 7'h2a;
    localparam int HOLD = 20;
    localparam int OSCS = 10;
    localparam int LIMIT = 80000;
    localparam logic [7:0] CORN [10] = '{8'ha5, 8'ha9, 8'ha6, 8'haa, 8'ha7, 8'hab,
        8'ha4, 8'ha1, 8'had, 8'h55};
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic osc_clk_i = 1'b0;
    logic power_fail_i = 1'b0;
    logic sda_o, sda_oe_o, reset_n_o, reset_n_oe_o, osc_run_o, charge_en_o, diode_on_o;
    logic [1:0] res_sel_o;
    logic [31:0] rng = 32'h4ab51d6c;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    wire logic scl, pull, sda;

    assign sda = ~(pull | sda_oe_o);
    always #20 ref_clk_i = ~ref_clk_i;

    sktk_top #(.DEV_ADDR(DEV), .HOLD_CYCLES(HOLD), .OSC_START_CYCLES(OSCS)) dut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .osc_clk_i(osc_clk_i),
        .power_fail_i(power_fail_i), .reset_n_o(reset_n_o), .reset_n_oe_o(reset_n_oe_o),
        .osc_run_o(osc_run_o), .charge_en_o(charge_en_o), .diode_on_o(diode_on_o),
        .res_sel_o(res_sel_o));
    sktk_bus_master m (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs

    function automatic logic [55:0] chg_exp(input logic [7:0] v);
        logic en;
        en = v[7:4] == 4'ha && (v[3:2] == 2'h1 || v[3:2] == 2'h2) && v[1:0] != 2'h0;
        return {52'h0, en, en && v[3:2] == 2'h2, en ? v[1:0] : 2'h0};
    endfunction : chg_exp

    task automatic check(input string what, input logic [55:0] seen, input logic [55:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            finish_test();
        end
    end

    task automatic hold_len(output int n);
        n = 0;
        while (reset_n_oe_o === 1'b1 && n < 500) begin
            @(negedge ref_clk_i);
            n++;
        end
    endtask : hold_len

    // Far too few edges for a whole second, so the count must not move.
    task automatic osc_pulses(input int k);
        repeat (k) begin
            repeat (4) @(negedge ref_clk_i);
            osc_clk_i = ~osc_clk_i;
        end
    endtask : osc_pulses

    task automatic rd_at(input logic [7:0] p, input int n, output logic [55:0] d);
        logic ok;
        m.wr(DEV, p, 0, 56'h0, ok);
        check("pointer ack", {55'h0, ok}, 56'h1);
        m.rd(DEV, n, d, ok);
        check("read ack", {55'h0, ok}, 56'h1);
    endtask : rd_at

    task automatic pf_cycle(input int lo, input logic run_exp);
        logic ok;
        int n;
        @(negedge ref_clk_i);
        power_fail_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        check("reset pin", {55'h0, reset_n_oe_o}, 56'h1);
        check("reset pin level", {55'h0, reset_n_o}, 56'h0);
        check("data pin level", {55'h0, sda_o}, 56'h0);
        check("osc run", {55'h0, osc_run_o}, {55'h0, run_exp});
        m.wr(DEV, 8'h04, 1, 56'h0, ok);
        check("ack in power fail", {55'h0, ok}, 56'h0);
        @(negedge ref_clk_i);
        power_fail_i = 1'b0;
        hold_len(n);
        check("hold window", {55'h0, n >= lo && n <= lo + 6}, 56'h1);
    endtask : pf_cycle

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic ok;
        logic [55:0] d;
        logic [31:0] c;
        logic [7:0] v;
        int n;
        repeat (2) @(negedge ref_clk_i);
        reset_i = 1'b0;
        check("charger at reset", {52'h0, charge_en_o, diode_on_o, res_sel_o}, 56'h0);
        hold_len(n);
        check("power-on hold", {55'h0, n >= HOLD && n <= HOLD + 6}, 56'h1);
        c = xs();
        m.wr(DEV, 8'h00, 4, {24'h0, c}, ok);
        check("write ack", {55'h0, ok}, 56'h1);
        rd_at(8'h00, 7, d);
        check("wrapped read", d, {c[7:0], 16'h0000, c});
        m.wr(DEV, 8'h05, 2, 56'h5c00, ok);
        c[7:0] = 8'h5c;
        m.rd(DEV, 3, d, ok);
        check("kept pointer read", d, {32'h0, c[31:8]});
        rd_at(8'h07, 1, d);
        check("out of range pointer", d, 56'h5c);
        m.wr(DEV ^ 7'h01, 8'h04, 1, 56'h80, ok);
        check("foreign address ack", {55'h0, ok}, 56'h0);
        osc_pulses(300);
        rd_at(8'h00, 5, d);
        check("counter below a second", d, {16'h0, 8'h00, c});
        for (int i = 0; i < 24; i++) begin
            v = (i < 10) ? CORN[i] : 8'(xs());
            m.wr(DEV, 8'h05, 1, {48'h0, v}, ok);
            check("charger outputs", {52'h0, charge_en_o, diode_on_o, res_sel_o},
                chg_exp(v));
            rd_at(8'h05, 1, d);
            check("charger register", d, {48'h0, v});
        end
        m.wr(DEV, 8'h04, 1, 56'h80, ok);
        check("osc on main supply", {55'h0, osc_run_o}, 56'h1);
        osc_pulses(100);
        pf_cycle(HOLD + OSCS, 1'b0);
        rd_at(8'h00, 5, d);
        check("registers after power fail", d, {16'h0, 8'h80, c});
        m.wr(DEV, 8'h04, 1, 56'h0, ok);
        pf_cycle(HOLD, 1'b1);
        finish_test();
    end
endmodule : tb
`default_nettype wire
